// *** wps_bench.sv ***
`timescale 1ns/1ps
// Host and device joined by the link, driven from the user sides
module wps_bench;
	import wps_pkg::*;
	localparam int SETTLE = 20;  // Short settle keeps the run brief
	logic       clock = 1'b0;
	logic       reset_n = 1'b0;
	logic       io_supply = 1'b0;
	logic       power_req = 1'b0;
	logic       fw_cfg_valid = 1'b0;
	logic [7:0] fw_out_en = 8'h00;
	logic [7:0] fw_pull_en = 8'h00;
	logic [1:0] fw_activity = 2'h0;
	logic       powered, settling, dcdc_on, core_supply_on, tx_allowed, rx_allowed;
	logic [7:0] pad_out_en, pad_in_en, pad_pull_en;
	logic [2:0] power_state;
	int         num_errors = 0;
	int         n_compared = 0;
	int         n;
	logic [2:0] exp_st;
	wps_link_if i_wps_link_if ();
	wps_host #(.SETTLE_CYC(SETTLE)) i_wps_host (.clock(clock), .reset_n(reset_n),
		.io_supply(io_supply), .power_req(power_req), .powered(powered),
		.settling(settling), .link(i_wps_link_if));
	wps_device i_wps_device (.clock(clock), .reset_n(reset_n), .link(i_wps_link_if),
		.fw_cfg_valid(fw_cfg_valid), .fw_out_en(fw_out_en), .fw_pull_en(fw_pull_en),
		.fw_activity(fw_activity), .dcdc_on(dcdc_on), .core_supply_on(core_supply_on),
		.pad_out_en(pad_out_en), .pad_in_en(pad_in_en), .pad_pull_en(pad_pull_en),
		.tx_allowed(tx_allowed), .rx_allowed(rx_allowed), .power_state(power_state));
	wps_check #(.SETTLE_CYC(SETTLE), .NUM_PINS(8)) i_wps_check (.clock(clock),
		.reset_n(reset_n), .converter_enable(i_wps_link_if.converter_enable),
		.hard_reset_low_in(i_wps_link_if.hard_reset_low_in), .dcdc_on(dcdc_on),
		.core_supply_on(core_supply_on), .pad_out_en(pad_out_en), .pad_in_en(pad_in_en),
		.pad_pull_en(pad_pull_en), .tx_allowed(tx_allowed), .rx_allowed(rx_allowed),
		.power_state(power_state));
	always #10 clock = ~clock;
	// Compares and counts
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Inputs move 1 ns after the edge, away from sampling
	task step;
		@(posedge clock);
		#1;
	endtask
	// State that an activity code selects; code 3 falls back to doze
	function logic [2:0] exp_state(input logic [1:0] act);
		return act == 2'h1 ? WPS_ST_RECV : (act == 2'h2 ? WPS_ST_XMIT : WPS_ST_DOZE);
	endfunction
	task end_of_test;
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Whole run is about 90 cycles
	initial begin
		#40000;
		num_errors++;
		end_of_test();
	end
	initial begin
		n = $urandom(32'h013273A2);
		repeat (16) @(posedge clock);
		#1 reset_n = 1'b1;
		// Request without supply must be ignored
		power_req = 1'b1;
		repeat (4) step();
		chk(i_wps_link_if.converter_enable, 0);
		io_supply = 1'b1;
		n = 0;
		while (!i_wps_link_if.converter_enable && n < 8) begin
			step();
			n++;
		end
		chk(i_wps_link_if.converter_enable, 1);
		n = 0;
		while (!i_wps_link_if.hard_reset_low_in && n < 99) begin
			if (n == 3) chk({pad_out_en, pad_in_en, pad_pull_en, dcdc_on}, 25'h1FF);
			if (n == 3) chk({powered, settling}, 2'b01);
			step();
			n++;
		end
		chk(n, SETTLE);
		chk({powered, settling}, 2'b10);
		step();
		chk({pad_out_en, pad_in_en, pad_pull_en, core_supply_on}, 25'h1FFFF);
		// Back-to-back firmware programming, every activity code first
		for (int i = 0; i < 24; i++) begin
			fw_out_en = (i == 0) ? 8'hFF : 8'($urandom);
			fw_pull_en = 8'($urandom);
			fw_activity = (i < 4) ? 2'(i) : 2'($urandom);
			fw_cfg_valid = 1'b1;
			step();
			chk({pad_out_en, pad_in_en, pad_pull_en}, {fw_out_en, ~fw_out_en, fw_pull_en});
			exp_st = exp_state(fw_activity);
			chk(power_state, exp_st);
			chk({tx_allowed, rx_allowed},
				{exp_st == WPS_ST_XMIT, exp_st == WPS_ST_RECV});
		end
		// Strobe low: new words on the inputs must not reach the pads
		fw_cfg_valid = 1'b0;
		fw_out_en = ~fw_out_en;
		fw_pull_en = ~fw_pull_en;
		step();
		chk({pad_out_en, pad_in_en, pad_pull_en}, {~fw_out_en, fw_out_en, ~fw_pull_en});
		chk(power_state, exp_st);
		power_req = 1'b0;
		n = 0;
		while (i_wps_link_if.converter_enable && n < 8) begin
			step();
			n++;
		end
		chk(i_wps_link_if.converter_enable, 0);
		chk(i_wps_link_if.hard_reset_low_in, 0);
		step();
		chk({pad_out_en, pad_in_en, pad_pull_en, core_supply_on, dcdc_on}, 0);
		// Request again straight after power-down; settle count restarts
		power_req = 1'b1;
		repeat (SETTLE + 2) step();
		chk({powered, i_wps_link_if.hard_reset_low_in, power_state}, {2'b11, WPS_ST_DEFAULT});
		end_of_test();
	end
endmodule

// *** wps_check_assertions.sv ***
`timescale 1ns/1ps
// Watches the link pins and the device pad outputs
module wps_check
	import wps_pkg::*;
#(
	parameter int SETTLE_CYC = WPS_SETTLE_CYC,
	parameter int NUM_PINS   = WPS_NUM_PINS
) (
	// Clock and reset
	input wire logic                clock,
	input wire logic                reset_n,
	// Link pins
	input wire logic                converter_enable,
	input wire logic                hard_reset_low_in,
	// Device outputs
	input wire logic                dcdc_on,
	input wire logic                core_supply_on,
	input wire logic [NUM_PINS-1:0] pad_out_en,
	input wire logic [NUM_PINS-1:0] pad_in_en,
	input wire logic [NUM_PINS-1:0] pad_pull_en,
	input wire logic                tx_allowed,
	input wire logic                rx_allowed,
	input wire logic [2:0]          power_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	int settle_reg;  // Cycles with enable high and reset held
	int settle_next;
	// Restarts whenever the link leaves the settle phase
	always_comb begin
		settle_next = (converter_enable && !hard_reset_low_in) ? settle_reg + 1 : 0;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			settle_reg <= 0;
		else
			settle_reg <= settle_next;
	end
	// Converter up, core still held in reset
	sequence s_por;
		converter_enable && !hard_reset_low_in;
	endsequence
	AST_SETTLE: assert property ($rose(hard_reset_low_in) |-> settle_reg == SETTLE_CYC)
		else $error("reset released off the settle count");
	AST_ORDER: assert property (hard_reset_low_in |-> converter_enable)
		else $error("reset high while enable low");
	AST_FALL: assert property ($fell(converter_enable) |-> !hard_reset_low_in)
		else $error("enable and reset fell apart");
	AST_DCDC: assert property ($stable(converter_enable) |-> dcdc_on == converter_enable)
		else $error("converter does not follow enable");
	AST_DOWN: assert property (!converter_enable |=> !core_supply_on && pad_out_en == '0
		&& pad_in_en == '0 && pad_pull_en == '0)
		else $error("pads or core live in power-down");
	AST_POR: assert property (s_por |=> pad_pull_en == '1 && pad_in_en == '0
		&& pad_out_en == '0)
		else $error("wrong pads in power-on reset");
	AST_OPP: assert property (power_state[1] |-> pad_in_en == ~pad_out_en)
		else $error("input buffers not opposite drivers");
	AST_DOZE: assert property (power_state == WPS_ST_DOZE |-> !tx_allowed && !rx_allowed
		&& core_supply_on)
		else $error("data moves in doze");
endmodule

// *** wps_device.sv ***
`timescale 1ns/1ps
// How it works
// - Converter follows converter-enable input
// - Host keeps enable high while on
// - Host lowers reset and enable to power-down
// - Host waits 5 ms before releasing reset
// - Host raises enable only after io_supply
// - Host always drives enable and reset
// - Host drops enable and reset together
// - Power-down: all drivers, inputs, pulls off
// - Power-on reset: pulls on, I/O off
// - Default: inputs and pulls on, outputs off
// - Doze keeps settings, no data movement
// - Power-down switches core supply off
module wps_device
	import wps_pkg::*;
#(
	parameter int NUM_PINS = WPS_NUM_PINS
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                reset_n,
	// Link from host
	wps_link_if.dev                  link,
	// Firmware pin programming
	input  wire logic                fw_cfg_valid,
	input  wire logic [NUM_PINS-1:0] fw_out_en,
	input  wire logic [NUM_PINS-1:0] fw_pull_en,
	input  wire logic [1:0]          fw_activity,
	// Power and pad control
	output logic                     dcdc_on,
	output logic                     core_supply_on,
	output logic [NUM_PINS-1:0]      pad_out_en,
	output logic [NUM_PINS-1:0]      pad_in_en,
	output logic [NUM_PINS-1:0]      pad_pull_en,
	// Data path gating and state view
	output logic                     tx_allowed,
	output logic                     rx_allowed,
	output logic [2:0]               power_state
);

	// Pin programming reset words fitted to this pin count; pins past the
	// package width start with drivers and pulls off, a known limitation
	localparam logic [NUM_PINS-1:0] OE_INIT   = NUM_PINS'(WPS_OE_RST);
	localparam logic [NUM_PINS-1:0] PULL_INIT = NUM_PINS'(WPS_PULL_RST);

	wps_state_t          state_reg, state_next;   // Device power state
	logic [NUM_PINS-1:0] oe_reg, oe_next;         // Programmed output drivers
	logic [NUM_PINS-1:0] pull_reg, pull_next;     // Programmed pulls
	logic [NUM_PINS-1:0] po_reg, po_next;         // Pad output enables
	logic [NUM_PINS-1:0] pi_reg, pi_next;         // Pad input enables
	logic [NUM_PINS-1:0] pp_reg, pp_next;         // Pad pull enables
	logic                dc_reg, dc_next;         // Converter enable
	logic                core_reg, core_next;     // Core supply switch
	logic                tx_reg, tx_next;         // Transmit path open
	logic                rx_reg, rx_next;         // Receive path open

	// Map a firmware activity code to an on state
	function automatic wps_state_t act_state(input logic [1:0] act);
		case (act)
			WPS_ACT_RECV: act_state = WPS_ST_RECV;
			WPS_ACT_XMIT: act_state = WPS_ST_XMIT;
			default:      act_state = WPS_ST_DOZE;
		endcase
	endfunction

	// Next state and pad settings; the pins are levels sampled every edge,
	// so a power-down or hard reset always wins over firmware programming
	// arriving in the same cycle
	always_comb begin
		state_next = state_reg;
		oe_next    = oe_reg;
		pull_next  = pull_reg;
		dc_next    = link.converter_enable;
		if (!link.converter_enable) begin
			// Enable low means power-down regardless of reset
			state_next = WPS_ST_DOWN;
			// Programming is lost together with the core supply
			oe_next    = OE_INIT;
			pull_next  = PULL_INIT;
		end else if (!link.hard_reset_low_in) begin
			// Hard reset drops any on state back to reset
			state_next = WPS_ST_POR;
			// Firmware must program the pins again after reset
			oe_next    = OE_INIT;
			pull_next  = PULL_INIT;
		end else begin
			case (state_reg)
				WPS_ST_DOWN: begin
					// Reset released together with enable
					state_next = WPS_ST_DEFAULT;
				end
				WPS_ST_POR: begin
					// Reset released after the crystal has settled
					state_next = WPS_ST_DEFAULT;
				end
				WPS_ST_DEFAULT, WPS_ST_DOZE, WPS_ST_RECV, WPS_ST_XMIT: begin
					// Firmware programming; doze keeps what was set
					if (fw_cfg_valid) begin
						oe_next    = fw_out_en;
						pull_next  = fw_pull_en;
						state_next = act_state(fw_activity);
					end
				end
				default: begin
					state_next = WPS_ST_DOWN;
				end
			endcase
		end
		// Pad behaviour follows the next state, so pads and state register
		// always change on the same edge
		case (state_next)
			WPS_ST_DOWN: begin
				// Core off: pins float, no buffers, no pulls
				po_next = '0;
				pi_next = '0;
				pp_next = '0;
			end
			WPS_ST_POR: begin
				po_next = '0;
				pi_next = '0;
				pp_next = '1;
			end
			WPS_ST_DEFAULT: begin
				// Out of reset, not yet programmed: listen only
				po_next = '0;
				pi_next = '1;
				pp_next = '1;
			end
			default: begin
				po_next = oe_next;
				pi_next = ~oe_next;
				pp_next = pull_next;
			end
		endcase
	end

	// State registers; reset looks like power-down
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= WPS_ST_DOWN;
			// Pins come up high-impedance until the host powers the core
			oe_reg    <= OE_INIT;
			pull_reg  <= PULL_INIT;
			po_reg    <= '0;
			pi_reg    <= '0;
			pp_reg    <= '0;
			dc_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			oe_reg    <= oe_next;
			pull_reg  <= pull_next;
			po_reg    <= po_next;
			pi_reg    <= pi_next;
			pp_reg    <= pp_next;
			dc_reg    <= dc_next;
		end
	end

	// Supply and data flags decoded from the next state, so that they leave
	// flip-flops directly and cannot glitch while the state bits change
	always_comb begin
		core_next = 1'b1;
		tx_next   = 1'b0;
		rx_next   = 1'b0;
		case (state_next)
			WPS_ST_DOWN: begin
				// Converter off, core unpowered
				core_next = 1'b0;
			end
			WPS_ST_XMIT: begin
				// Only the transmit state opens the transmit path
				tx_next = 1'b1;
			end
			WPS_ST_RECV: begin
				// Only the receive state opens the receive path
				rx_next = 1'b1;
			end
			default: begin
				// Reset, default and doze stay powered but move no data
				tx_next = 1'b0;
				rx_next = 1'b0;
			end
		endcase
	end

	// Flag registers; reset reads as power-down
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			core_reg <= 1'b0;
			tx_reg   <= 1'b0;
			rx_reg   <= 1'b0;
		end else begin
			core_reg <= core_next;
			tx_reg   <= tx_next;
			rx_reg   <= rx_next;
		end
	end

	// Outputs, all straight from flip-flops; doze gates both directions
	assign dcdc_on        = dc_reg;
	assign core_supply_on = core_reg;
	assign pad_out_en     = po_reg;
	assign pad_in_en      = pi_reg;
	assign pad_pull_en    = pp_reg;
	assign tx_allowed     = tx_reg;
	assign rx_allowed     = rx_reg;
	assign power_state    = state_reg;

endmodule

// *** wps_host.sv ***
`timescale 1ns/1ps
// Host sequencer driving converter enable and hard reset
module wps_host
	import wps_pkg::*;
#(
	parameter int SETTLE_CYC = WPS_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset_n,
	// User side
	input  wire logic io_supply,
	input  wire logic power_req,
	output logic      powered,
	output logic      settling,
	// Link to module
	wps_link_if.host  link
);

	wps_hstate_t state_reg, state_next;  // Sequencer state
	logic [31:0] cnt_reg, cnt_next;      // Settle counter

	// Next state
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			WPS_H_OFF: begin
				// Enable only once io_supply is present
				if (power_req && io_supply) begin
					state_next = WPS_H_SETTLE;
					cnt_next   = 32'h0;
				end
			end
			WPS_H_SETTLE: begin
				// Hold reset while the crystal settles
				if (!power_req || !io_supply) begin
					state_next = WPS_H_OFF;
				end else if (cnt_reg >= 32'(SETTLE_CYC - 1)) begin
					state_next = WPS_H_ON;
				end else begin
					cnt_next = cnt_reg + 32'h1;
				end
			end
			WPS_H_ON: begin
				// Both pins fall in the same cycle
				if (!power_req || !io_supply) begin
					state_next = WPS_H_OFF;
				end
			end
			default: begin
				state_next = WPS_H_OFF;
			end
		endcase
	end

	// Registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= WPS_H_OFF;
			cnt_reg   <= 32'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// Pins always driven to a level, never floating
	assign link.converter_enable  = (state_reg != WPS_H_OFF);
	assign link.hard_reset_low_in = (state_reg == WPS_H_ON);
	assign powered                = (state_reg == WPS_H_ON);
	assign settling               = (state_reg == WPS_H_SETTLE);

endmodule

// *** wps_link_if.sv ***
`timescale 1ns/1ps
// Enable and hard-reset pins between host and module
interface wps_link_if;
	logic converter_enable;
	logic hard_reset_low_in;
	modport host (output converter_enable, output hard_reset_low_in);
	modport dev (input converter_enable, input hard_reset_low_in);
endinterface

// *** wps_pkg.sv ***
package wps_pkg;

	// Device power states, Gray coded along power-up path
	typedef enum logic [2:0] {
		WPS_ST_DOWN    = 3'h0,
		WPS_ST_POR     = 3'h1,
		WPS_ST_DEFAULT = 3'h3,
		WPS_ST_DOZE    = 3'h2,
		WPS_ST_RECV    = 3'h6,
		WPS_ST_XMIT    = 3'h7
	} wps_state_t;

	// Firmware activity request encoding
	typedef enum logic [1:0] {
		WPS_ACT_DOZE = 2'h0,
		WPS_ACT_RECV = 2'h1,
		WPS_ACT_XMIT = 2'h2
	} wps_act_t;

	// Host sequencer states, Gray coded
	typedef enum logic [1:0] {
		WPS_H_OFF    = 2'h0,
		WPS_H_SETTLE = 2'h1,
		WPS_H_ON     = 2'h3
	} wps_hstate_t;

	// Clock rate and crystal settle time
	localparam int WPS_CLK_HZ     = 50000000;
	localparam int WPS_SETTLE_MS  = 5;
	localparam int WPS_SETTLE_CYC = (WPS_CLK_HZ / 1000) * WPS_SETTLE_MS;

	// Number of digital I/O pins managed
	localparam int WPS_NUM_PINS = 8;

	// Reset values of firmware pin programming
	localparam logic [WPS_NUM_PINS-1:0] WPS_OE_RST   = 8'h00;
	localparam logic [WPS_NUM_PINS-1:0] WPS_PULL_RST = 8'hFF;

endpackage
